//--- src/mbd_map.vh
// Purpose: constants for the module base decode and configuration block
// Assumes: 16-bit register words, byte addresses
// Notes: offsets of the block registers are relative to the module base
`ifndef MBD_MAP_VH
`define MBD_MAP_VH

// cpu-space addresses of the module base register halves
`define MBD_BASE_UPPER_ADDR 32'h0003ff00
`define MBD_BASE_LOWER_ADDR 32'h0003ff02
`define MBD_FC_CPU 3'h7
`define MBD_FC_SUP_DATA 3'h5

// offsets inside the 4k block
`define MBD_OFS_CONFIG 12'h000
`define MBD_OFS_AUTOVEC 12'h004
`define MBD_OFS_RSTCAUSE 12'h006

// module_base_lower fields
`define MBD_BASE_VALID_BIT 0
`define MBD_SPACE_MASK_LSB 1

// module_config_reg fields
`define MBD_CFG_FRZ_WDOG 14
`define MBD_CFG_FRZ_TIMER 13
`define MBD_CFG_AUTOVECTOR_SELECT_SEL 12
`define MBD_CFG_SHOW_LSB 8
`define MBD_CFG_SUPERVISOR_RESTRICT 7
`define MBD_CFG_IARB_LSB 0

// reset values
`define MBD_RST_BASE_UPPER 16'h0000
`define MBD_RST_BASE_LOWER 16'h0000
`define MBD_RST_CONFIG 16'h000f
`define MBD_RST_AUTOVEC 8'h00
`define MBD_RST_RSTCAUSE 8'h00
`define MBD_CFG_WR_MASK 16'h738f

// reset cause bit positions
`define MBD_CAUSE_EXT 0
`define MBD_CAUSE_POW 1
`define MBD_CAUSE_WDOG 2
`define MBD_CAUSE_DBF 3
`define MBD_CAUSE_LOC 4
`define MBD_CAUSE_SYS 5

`endif

//--- src/mbd_top.v
// Purpose: module base decode, configuration, autovector and reset-cause registers
// Assumes: one core request at a time, answered one clock after it is taken
// Notes: show cycles mirror block register accesses on the external pins; base register accesses get none
//
// Summary of operation
// - block starts at base taken from upper twenty base bits, any 4k boundary.
// - eight mask bits, one per function code; set bit sends cycle external.
// - while valid flag clear, block registers are unreachable.
// - base register accesses never run on the external bus.
// - base register answers at fixed cpu-space address with function code 7.
// - watchdog-freeze bit plus debug halt stops watchdog counters.
// - timer-freeze bit plus debug halt stops periodic timer counters.
// - autovector select disables chip select zero and makes pin autovector input.
// - show field: 00 no show/arb on, 01 show/arb off, 1x show/arb on.
// - show cycle drives address, data, control but not address strobe.
// - internal access without show cycles leaves pins and strobes idle.
// - with arbitration off, external bus requests are ignored.
// - upper show bit: request makes core abandon; resume after request and ack negate.
// - supervisor restrict: shared registers need supervisor data code; else bus error.
// - restrict clear: shared registers reachable without privilege check.
// - arbitration priority resets to all ones.
// - priority zero: no arbitration, every interrupt discarded as extraneous.
// - autovector bit per level gives internal autovector in acknowledge cycle.
// - autovectoring only while priority is nonzero.
// - reset cause holds one bit, latest cause, updated at reset end, read only.
// - causes: pin, power-up, watchdog, double fault, clock loss, reset instruction.
// - debug halt comes from the core on breakpoint in background mode.
`timescale 1ns/1ns
`include "mbd_map.vh"

module mbd_top (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // core bus cycle
  input wire CPU_REQ,
  input wire CPU_WR,
  input wire [31:0] CPU_ADDR,
  input wire [2:0] CPU_FC,
  input wire [15:0] CPU_WDATA,
  output reg [15:0] CPU_RDATA,
  output reg CPU_ACK,
  output reg CPU_BUS_ERROR_RESP,
  output reg CPU_EXT,
  // core status
  input wire FREEZE,
  input wire [5:0] RST_CAUSE,
  // timers
  output wire WDOG_STOP,
  output wire PIT_STOP,
  // chip select zero pin use
  output wire CS0_ENABLE,
  output wire AUTOVECTOR_SELECT_PIN_MODE,
  // interrupt acknowledge
  input wire INTERRUPT_ACK_CYCLE_REQ,
  input wire [2:0] INTERRUPT_ACK_CYCLE_LEVEL,
  output wire IARB_ACTIVE,
  output wire [3:0] IARB_LEVEL,
  output reg AUTOVEC_RESP,
  output reg IRQ_DISCARD,
  // external arbitration pins
  input wire BR_N,
  input wire GRANT_ACK_IN_N,
  output wire SHOW_ENABLE,
  output wire ARB_ENABLE,
  output wire EXT_REQ_SEEN,
  output wire CORE_ABANDON,
  output wire CORE_HOLD,
  // show cycle pins
  output reg [31:0] EXT_ADDR,
  output reg EXT_ADDR_OE,
  output reg [15:0] EXT_DATA,
  output reg EXT_DATA_OE,
  output reg EXT_RW,
  output reg EXT_DS_N,
  output wire EXT_AS_N,
  output wire EXT_AS_OE
);

  reg [15:0] base_upper_r;
  reg [15:0] base_lower_r;
  reg [15:0] config_r;
  reg [7:0] autovec_r;
  reg [7:0] rstcause_r;
  reg cause_done_r;
  reg br_s1_r;
  reg br_s2_r;
  reg grant_ack_in_s1_r;
  reg grant_ack_in_s2_r;
  reg [1:0] show_st_r;
  reg [1:0] show_st_nxt;
  reg [7:0] cause_pick;

  wire [19:0] module_base_field;
  wire [7:0] space_mask_bits;
  wire base_valid;
  wire [1:0] show_cycle_ctrl;
  wire supervisor_restrict;
  wire [3:0] int_arb_priority;
  wire hit_base_upper;
  wire hit_base_lower;
  wire hit_block;
  wire [11:0] ofs;
  wire priv_ok;
  wire cfg_priv_ok;
  wire show_go;

  // show cycle sequencer states
  localparam [1:0] sh_idle = 2'h0;
  localparam [1:0] sh_strb = 2'h1;
  localparam [1:0] sh_hold = 2'h2;

  assign module_base_field = {base_upper_r, base_lower_r[15:12]};
  assign space_mask_bits = base_lower_r[`MBD_SPACE_MASK_LSB+7:`MBD_SPACE_MASK_LSB];
  assign base_valid = base_lower_r[`MBD_BASE_VALID_BIT];
  assign show_cycle_ctrl = config_r[`MBD_CFG_SHOW_LSB+1:`MBD_CFG_SHOW_LSB];
  assign supervisor_restrict = config_r[`MBD_CFG_SUPERVISOR_RESTRICT];
  assign int_arb_priority = config_r[`MBD_CFG_IARB_LSB+3:`MBD_CFG_IARB_LSB];

  // base register halves sit in cpu space only
  assign hit_base_upper = (CPU_FC == `MBD_FC_CPU) &&
    (CPU_ADDR == `MBD_BASE_UPPER_ADDR);
  assign hit_base_lower = (CPU_FC == `MBD_FC_CPU) &&
    (CPU_ADDR == `MBD_BASE_LOWER_ADDR);

  // block select: valid, upper twenty address bits match, space not masked
  assign hit_block = base_valid &&
    (CPU_ADDR[31:12] == module_base_field) &&
    !space_mask_bits[CPU_FC] &&
    !hit_base_upper && !hit_base_lower;
  assign ofs = CPU_ADDR[11:0];

  // shared registers: supervisor data only when restricted, open otherwise
  assign priv_ok = supervisor_restrict ? (CPU_FC == `MBD_FC_SUP_DATA) : 1'b1;
  // configuration register is supervisor only
  assign cfg_priv_ok = CPU_FC[2];

  // core register access, answered one clock later
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      base_upper_r <= `MBD_RST_BASE_UPPER;
      base_lower_r <= `MBD_RST_BASE_LOWER;
      config_r <= `MBD_RST_CONFIG;
      autovec_r <= `MBD_RST_AUTOVEC;
      CPU_RDATA <= 16'h0000;
      CPU_ACK <= 1'b0;
      CPU_BUS_ERROR_RESP <= 1'b0;
      CPU_EXT <= 1'b0;
    end else begin
      CPU_ACK <= 1'b0;
      CPU_BUS_ERROR_RESP <= 1'b0;
      CPU_EXT <= 1'b0;
      CPU_RDATA <= 16'h0000;
      if (CPU_REQ) begin
        if (hit_base_upper || hit_base_lower) begin
          // answered internally, never an external cycle
          CPU_ACK <= 1'b1;
          if (CPU_WR) begin
            if (hit_base_upper)
              base_upper_r <= CPU_WDATA;
            else
              base_lower_r <= {CPU_WDATA[15:12], 3'h0, CPU_WDATA[8:0]};
          end else begin
            CPU_RDATA <= hit_base_upper ? base_upper_r : base_lower_r;
          end
        end else if (hit_block) begin
          case (ofs)
            `MBD_OFS_CONFIG: begin
              if (cfg_priv_ok) begin
                CPU_ACK <= 1'b1;
                if (CPU_WR)
                  config_r <= CPU_WDATA & `MBD_CFG_WR_MASK;
                else
                  CPU_RDATA <= config_r;
              end else begin
                CPU_BUS_ERROR_RESP <= 1'b1;
              end
            end
            `MBD_OFS_AUTOVEC: begin
              if (priv_ok) begin
                CPU_ACK <= 1'b1;
                if (CPU_WR)
                  autovec_r <= CPU_WDATA[7:0];
                else
                  CPU_RDATA <= {8'h00, autovec_r};
              end else begin
                CPU_BUS_ERROR_RESP <= 1'b1;
              end
            end
            `MBD_OFS_RSTCAUSE: begin
              // writes are acknowledged and dropped
              if (priv_ok) begin
                CPU_ACK <= 1'b1;
                if (!CPU_WR)
                  CPU_RDATA <= {8'h00, rstcause_r};
              end else begin
                CPU_BUS_ERROR_RESP <= 1'b1;
              end
            end
            default: begin
              CPU_ACK <= 1'b1;
            end
          endcase
        end else begin
          // masked space, invalid base or other address: external bus takes it
          CPU_EXT <= 1'b1;
        end
      end
    end
  end

  // reset cause: lowest set source wins so exactly one bit is left
  always @* begin
    cause_pick = 8'h00;
    if (RST_CAUSE[`MBD_CAUSE_EXT])
      cause_pick[`MBD_CAUSE_EXT] = 1'b1;
    else if (RST_CAUSE[`MBD_CAUSE_POW])
      cause_pick[`MBD_CAUSE_POW] = 1'b1;
    else if (RST_CAUSE[`MBD_CAUSE_WDOG])
      cause_pick[`MBD_CAUSE_WDOG] = 1'b1;
    else if (RST_CAUSE[`MBD_CAUSE_DBF])
      cause_pick[`MBD_CAUSE_DBF] = 1'b1;
    else if (RST_CAUSE[`MBD_CAUSE_LOC])
      cause_pick[`MBD_CAUSE_LOC] = 1'b1;
    else if (RST_CAUSE[`MBD_CAUSE_SYS])
      cause_pick[`MBD_CAUSE_SYS] = 1'b1;
    else
      cause_pick[`MBD_CAUSE_EXT] = 1'b1;
  end

  // captured on the first edge after reset release
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rstcause_r <= `MBD_RST_RSTCAUSE;
      cause_done_r <= 1'b0;
    end else if (!cause_done_r) begin
      rstcause_r <= cause_pick;
      cause_done_r <= 1'b1;
    end
  end

  // freeze comes from the core on a background-mode breakpoint
  assign WDOG_STOP = FREEZE && config_r[`MBD_CFG_FRZ_WDOG];
  assign PIT_STOP = FREEZE && config_r[`MBD_CFG_FRZ_TIMER];

  assign AUTOVECTOR_SELECT_PIN_MODE = config_r[`MBD_CFG_AUTOVECTOR_SELECT_SEL];
  assign CS0_ENABLE = !config_r[`MBD_CFG_AUTOVECTOR_SELECT_SEL];

  // interrupt acknowledge answer
  assign IARB_ACTIVE = int_arb_priority != 4'h0;
  assign IARB_LEVEL = int_arb_priority;

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      AUTOVEC_RESP <= 1'b0;
      IRQ_DISCARD <= 1'b0;
    end else begin
      AUTOVEC_RESP <= INTERRUPT_ACK_CYCLE_REQ && IARB_ACTIVE && autovec_r[INTERRUPT_ACK_CYCLE_LEVEL];
      IRQ_DISCARD <= INTERRUPT_ACK_CYCLE_REQ && !IARB_ACTIVE;
    end
  end

  // arbitration pins come from outside, two flops first
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      br_s1_r <= 1'b0;
      br_s2_r <= 1'b0;
      grant_ack_in_s1_r <= 1'b0;
      grant_ack_in_s2_r <= 1'b0;
    end else begin
      br_s1_r <= !BR_N;
      br_s2_r <= br_s1_r;
      grant_ack_in_s1_r <= !GRANT_ACK_IN_N;
      grant_ack_in_s2_r <= grant_ack_in_s1_r;
    end
  end

  assign SHOW_ENABLE = show_cycle_ctrl != 2'b00;
  assign ARB_ENABLE = show_cycle_ctrl != 2'b01;
  assign EXT_REQ_SEEN = ARB_ENABLE && br_s2_r;
  assign CORE_ABANDON = show_cycle_ctrl[1] && br_s2_r;
  assign CORE_HOLD = show_cycle_ctrl[1] && (br_s2_r || grant_ack_in_s2_r);

  // show cycle: strobe phase marks address, hold phase keeps data after strobe rises
  assign show_go = CPU_REQ && hit_block && SHOW_ENABLE;

  always @* begin
    show_st_nxt = show_st_r;
    case (show_st_r)
      sh_idle: begin
        if (show_go)
          show_st_nxt = sh_strb;
      end
      sh_strb: begin
        show_st_nxt = sh_hold;
      end
      sh_hold: begin
        show_st_nxt = show_go ? sh_strb : sh_idle;
      end
      default: begin
        show_st_nxt = sh_idle;
      end
    endcase
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      show_st_r <= sh_idle;
      EXT_ADDR <= 32'h00000000;
      EXT_ADDR_OE <= 1'b0;
      EXT_DATA <= 16'h0000;
      EXT_DATA_OE <= 1'b0;
      EXT_RW <= 1'b1;
      EXT_DS_N <= 1'b1;
    end else begin
      show_st_r <= show_st_nxt;
      if (show_st_nxt == sh_strb) begin
        EXT_ADDR <= CPU_ADDR;
        EXT_ADDR_OE <= 1'b1;
        EXT_DATA <= CPU_WR ? CPU_WDATA : 16'h0000;
        EXT_DATA_OE <= 1'b1;
        EXT_RW <= !CPU_WR;
        EXT_DS_N <= 1'b0;
      end else if (show_st_nxt == sh_hold) begin
        // read data is only known now; keep it valid past the strobe
        if (EXT_RW)
          EXT_DATA <= CPU_RDATA;
        EXT_DS_N <= 1'b1;
      end else begin
        EXT_ADDR_OE <= 1'b0;
        EXT_DATA_OE <= 1'b0;
        EXT_RW <= 1'b1;
        EXT_DS_N <= 1'b1;
      end
    end
  end

  // address strobe is never driven for internal accesses
  assign EXT_AS_N = 1'b1;
  assign EXT_AS_OE = 1'b0;

endmodule

//--- src/mbd_unused.v
`timescale 1ns/1ns

//--- test/mbd_ext_master.sv
// Purpose: external bus master model on the arbitration pins
// Assumes: the block synchronises both pins itself
// Notes: rude lets a scenario request during a show-only window
`timescale 1ns/1ns
module mbd_ext_master (
  // clock and command
  input logic clk,
  input logic want,
  input logic rude,
  // block mode
  input logic show_en,
  input logic arb_en,
  // pins
  output logic br_n,
  output logic grant_ack_in_n
);
  initial begin
    br_n = 1'b1;
    grant_ack_in_n = 1'b1;
  end
  always @(posedge clk) begin
    // no request while show cycles run with arbitration off
    br_n <= #1 !(want && (rude || !(show_en && !arb_en)));
    grant_ack_in_n <= #1 br_n;
  end
endmodule

//--- test/mbd_top_asserts.sv
// Purpose: port-level checks of the base decode block
// Assumes: one clock, reset active high
// Notes: attached by bind below
`timescale 1ns/1ns
module mbd_top_asserts (
  // clock and reset
  input logic CORE_CLK,
  input logic RST,
  // core side
  input logic CPU_REQ,
  input logic [31:0] CPU_ADDR,
  input logic [2:0] CPU_FC,
  input logic CPU_ACK,
  input logic CPU_BUS_ERROR_RESP,
  input logic CPU_EXT,
  // status
  input logic FREEZE,
  input logic WDOG_STOP,
  input logic PIT_STOP,
  input logic CS0_ENABLE,
  input logic AUTOVECTOR_SELECT_PIN_MODE,
  input logic INTERRUPT_ACK_CYCLE_REQ,
  input logic IARB_ACTIVE,
  input logic [3:0] IARB_LEVEL,
  input logic AUTOVEC_RESP,
  input logic IRQ_DISCARD,
  // external bus
  input logic SHOW_ENABLE,
  input logic ARB_ENABLE,
  input logic EXT_REQ_SEEN,
  input logic CORE_ABANDON,
  input logic CORE_HOLD,
  input logic EXT_DATA_OE,
  input logic EXT_DS_N,
  input logic EXT_AS_N,
  input logic EXT_AS_OE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence base_hit;
    CPU_REQ && CPU_FC == 3'h7 && (CPU_ADDR == 32'h0003ff00 || CPU_ADDR == 32'h0003ff02);
  endsequence
  sequence show_off;
    !SHOW_ENABLE [*4];
  endsequence
  a_one_answer: assert property (CPU_REQ |=> $onehot({CPU_ACK, CPU_BUS_ERROR_RESP, CPU_EXT}))
    else $error("request not answered once");
  a_base_local: assert property (base_hit |=> CPU_ACK)
    else $error("base register access not local");
  a_freeze_gate: assert property (!FREEZE |-> !WDOG_STOP && !PIT_STOP)
    else $error("timers stopped without halt");
  a_cs0_swap: assert property (CS0_ENABLE != AUTOVECTOR_SELECT_PIN_MODE)
    else $error("chip select zero use wrong");
  a_show_decode: assert property (!SHOW_ENABLE |-> ARB_ENABLE)
    else $error("show field decode wrong");
  a_as_never: assert property (EXT_AS_N && !EXT_AS_OE)
    else $error("address strobe driven");
  a_show_frame: assert property (
    $fell(EXT_DS_N) |-> EXT_DATA_OE ##1 EXT_DS_N && EXT_DATA_OE)
    else $error("show frame wrong");
  a_no_show: assert property (show_off |-> EXT_DS_N && !EXT_DATA_OE)
    else $error("pins driven without show");
  a_arb_off: assert property (!ARB_ENABLE |-> !EXT_REQ_SEEN)
    else $error("request seen with arbitration off");
  a_abandon_hold: assert property (CORE_ABANDON |-> CORE_HOLD)
    else $error("abandon without hold");
  a_interrupt_ack_cycle_zero: assert property (
    INTERRUPT_ACK_CYCLE_REQ && !IARB_ACTIVE |=> IRQ_DISCARD && !AUTOVEC_RESP)
    else $error("interrupt_ack_cycle with priority zero kept");
  a_iarb_act: assert property (IARB_ACTIVE == (IARB_LEVEL != 4'h0))
    else $error("arbitration active wrong");
endmodule
bind mbd_top mbd_top_asserts u_mbd_top_asserts (.*);

//--- test/tb_mbd_top.sv
// Purpose: self-checking bench of the base decode block
// Assumes: answers one clock after a request is taken
// Notes: random base, config and autovector values
`timescale 1ns/1ns
module tb_mbd_top;
  logic CORE_CLK = 0;
  logic RST = 1;
  logic CPU_REQ = 0;
  logic CPU_WR = 0;
  logic [31:0] CPU_ADDR = 0;
  logic [2:0] CPU_FC = 0;
  logic [15:0] CPU_WDATA = 0;
  logic FREEZE = 0;
  logic [5:0] RST_CAUSE = 0;
  logic INTERRUPT_ACK_CYCLE_REQ = 0;
  logic [2:0] INTERRUPT_ACK_CYCLE_LEVEL = 0;
  logic [15:0] CPU_RDATA, EXT_DATA;
  logic [31:0] EXT_ADDR;
  logic [3:0] IARB_LEVEL;
  logic CPU_ACK, CPU_BUS_ERROR_RESP, CPU_EXT, WDOG_STOP, PIT_STOP, CS0_ENABLE, AUTOVECTOR_SELECT_PIN_MODE;
  logic IARB_ACTIVE, AUTOVEC_RESP, IRQ_DISCARD, BR_N, GRANT_ACK_IN_N, SHOW_ENABLE, ARB_ENABLE;
  logic EXT_REQ_SEEN, CORE_ABANDON, CORE_HOLD, EXT_ADDR_OE, EXT_DATA_OE, EXT_RW;
  logic EXT_DS_N, EXT_AS_N, EXT_AS_OE;
  logic want = 0;
  logic rude = 0;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'hb2dcf5ac;
  logic [19:0] base;
  logic [15:0] rd, w, e;
  logic [5:0] rc;
  logic [2:0] rsp;
  logic ds_low;
  logic [31:0] sa;
  logic [1:0] so;
  mbd_top u_mbd_top (.*);
  mbd_ext_master u_mbd_ext_master (.clk(CORE_CLK), .want(want), .rude(rude),
    .show_en(SHOW_ENABLE), .arb_en(ARB_ENABLE), .br_n(BR_N), .grant_ack_in_n(GRANT_ACK_IN_N));
  always #25 CORE_CLK = ~CORE_CLK;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task acc(input logic wr, input logic [31:0] a, input logic [2:0] fc, input logic [15:0] wd);
    @(posedge CORE_CLK) #1 CPU_REQ = 1;
    CPU_WR = wr;
    CPU_ADDR = a;
    CPU_FC = fc;
    CPU_WDATA = wd;
    @(posedge CORE_CLK) #1 CPU_REQ = 0;
    rsp = {CPU_EXT, CPU_BUS_ERROR_RESP, CPU_ACK};
    rd = CPU_RDATA;
    ds_low = !EXT_DS_N;
    sa = EXT_ADDR;
    so = {EXT_ADDR_OE, EXT_RW};
  endtask
  task setb(input logic [7:0] m);
    acc(1, 32'h0003ff00, 3'h7, base[19:4]);
    acc(1, 32'h0003ff02, 3'h7, {base[3:0], 3'h0, m, 1'b1});
  endtask
  task rst(input logic [5:0] c);
    #1 RST = 1;
    RST_CAUSE = c;
    repeat (4) @(posedge CORE_CLK);
    #1 RST = 0;
  endtask
  function logic [31:0] ba(input logic [11:0] o);
    ba = {base, o};
  endfunction
  function logic [7:0] cause(input logic [5:0] c);
    cause = 8'h01;
    for (int i = 5; i >= 0; i--) if (c[i]) cause = 8'h01 << i;
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #2000000 miscompares++;
    close_out;
  end
  initial begin
    rst(6'h01);
    chk({IARB_ACTIVE, IARB_LEVEL, CS0_ENABLE, ARB_ENABLE, SHOW_ENABLE}, 8'hfe);
    base = {1'b1, 19'($random(seed))};
    acc(0, ba(12'h000), 3'h5, 0); chk(rsp, 3'b100);
    acc(0, 32'h0003ff00, 3'h7, 0); chk({rsp, rd}, {3'b001, 16'h0});
    acc(0, 32'h0003ff00, 3'h5, 0); chk(rsp, 3'b100);
    setb(8'h00);
    acc(0, 32'h0003ff02, 3'h7, 0);
    chk({rsp, rd, ds_low}, {3'b001, base[3:0], 12'h001, 1'b0});
    acc(0, ba(12'h000), 3'h5, 0); chk({rsp, rd}, {3'b001, 16'h000f});
    acc(0, ba(12'h00e), 3'h5, 0); chk({rsp, rd}, {3'b001, 16'h0});
    acc(0, ba(12'h000) + 32'h1000, 3'h5, 0); chk(rsp, 3'b100);
    $display("test base done");
    for (int f = 0; f < 8; f++) begin
      setb(8'h01 << f);
      acc(0, ba(12'h000), 3'(f), 0); chk(rsp, 3'b100);
      acc(0, ba(12'h000), 3'(f ^ 1), 0); chk(rsp, (f ^ 1) > 3 ? 3'b001 : 3'b010);
    end
    setb(8'h00);
    $display("test mask done");
    for (int i = 0; i < 12; i++) begin
      w = 16'($random(seed));
      if (i < 4) w[9:8] = 2'(i);
      FREEZE = w[15];
      acc(1, ba(12'h000), 3'h5, w);
      acc(0, ba(12'h000), 3'h5, 0);
      e = w & 16'h738f;
      chk({rsp, rd}, {3'b001, e});
      chk({ds_low, so}, {e[9] | e[8], e[9] | e[8], 1'b1});
      if (e[9] | e[8]) chk(sa, ba(12'h000));
      chk({WDOG_STOP, PIT_STOP}, {FREEZE & e[14], FREEZE & e[13]});
      chk({AUTOVECTOR_SELECT_PIN_MODE, CS0_ENABLE}, {e[12], !e[12]});
      chk({SHOW_ENABLE, ARB_ENABLE}, {e[9] | e[8], e[9] | !e[8]});
      // hold phase: strobe back up, read data kept on the pins
      @(posedge CORE_CLK) #1 chk({EXT_DATA_OE, EXT_DS_N}, {e[9] | e[8], 1'b1});
      if (e[9] | e[8]) chk(EXT_DATA, e);
    end
    $display("test config done");
    acc(1, ba(12'h000), 3'h5, 16'h0100);
    want = 1;
    repeat (6) @(posedge CORE_CLK);
    #1 chk({BR_N, EXT_REQ_SEEN, CORE_ABANDON}, 3'b100);
    rude = 1;
    repeat (6) @(posedge CORE_CLK);
    #1 chk({BR_N, EXT_REQ_SEEN}, 2'b00);
    acc(1, ba(12'h000), 3'h5, 16'h0200);
    acc(0, 32'h0003ff02, 3'h7, 0); chk({rsp, ds_low}, {3'b001, 1'b0});
    rude = 0;
    repeat (6) @(posedge CORE_CLK);
    #1 chk({EXT_REQ_SEEN, CORE_ABANDON, CORE_HOLD}, 3'b111);
    want = 0;
    repeat (6) @(posedge CORE_CLK);
    #1 chk({CORE_ABANDON, CORE_HOLD}, 2'b00);
    $display("test arbitration done");
    acc(1, ba(12'h000), 3'h5, 16'h008f);
    acc(1, ba(12'h004), 3'h1, 16'h00a5); chk(rsp, 3'b010);
    acc(0, ba(12'h004), 3'h5, 0); chk({rsp, rd}, {3'b001, 16'h0});
    acc(1, ba(12'h000), 3'h5, 16'h000f);
    acc(1, ba(12'h004), 3'h1, 16'h00a5);
    acc(0, ba(12'h004), 3'h2, 0); chk({rsp, rd}, {3'b001, 16'h00a5});
    $display("test privilege done");
    for (int p = 0; p < 2; p++) begin
      w = 16'($random(seed));
      // priority kept in the recommended range when nonzero
      acc(1, ba(12'h000), 3'h5, {12'h0, p ? 4'h0 : w[3:0] | 4'h1});
      acc(1, ba(12'h004), 3'h5, {8'h0, w[15:8]});
      for (int l = 1; l < 8; l++) begin
        @(posedge CORE_CLK) #1 INTERRUPT_ACK_CYCLE_REQ = 1;
        INTERRUPT_ACK_CYCLE_LEVEL = 3'(l);
        @(posedge CORE_CLK) #1 INTERRUPT_ACK_CYCLE_REQ = 0;
        chk({AUTOVEC_RESP, IRQ_DISCARD}, {p == 0 && w[8 + l], p == 1});
      end
    end
    $display("test interrupt_ack_cycle done");
    for (int c = 0; c < 7; c++) begin
      rc = c < 6 ? 6'h01 << c : 6'($random(seed));
      rst(rc);
      setb(8'h00);
      acc(1, ba(12'h006), 3'h5, 16'h00ff);
      acc(0, ba(12'h006), 3'h5, 0); chk({rsp, rd}, {3'b001, 8'h0, cause(rc)});
    end
    $display("test reset cause done");
    close_out;
  end
endmodule
